// ---- atg_top.sv ----
// Contract
// - eight channels, each own parameters, indexed
// - sample resolution 24 or 20 bits
// - alignment: free run or three frame resets
// - free run ignores frame-reset pulses
// - frame-reset restart restarts audio timing
// - outputs placed against reference plus offset
// - 48 kHz word clock, own offset, always
// - thirty tones plus inactive and silence
// - inactive channel outputs no audio data
// - level -60 to 0 dBFS, 1 dB
// - click every 1 to 4 s, or off
// - quarter second mute holds the click
// - clicks off means continuous tone
// - offset 1 us steps, +-160 ms
// - negative advances, positive delays audio
// - one command clears offset to zero
// - offset writes ignored in free run
// - defaults: 1000 Hz, -20 dBFS, clicks off
// - defaults: 20 bits, free run, zero offset
`timescale 1ns/100ps
`default_nettype none
`include "atg_cfg.svh"

module atg_top (
   input wire logic clk,
   input wire logic clk_en,
   input wire logic sys_rst,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [2:0] fr_pulse,
   output logic [191:0] aud_data,
   output logic [7:0] aud_active,
   output logic aud_strobe,
   output logic word_clk
);
   localparam int NCH = `ATG_NCH;

   logic res24_q;
   atg_pkg::atg_sync_type sync_q;
   logic signed [18:0] ofs_q;
   logic [4:0] wc_ofs_q;
   logic [2:0] chsel_q;
   logic [4:0] freq_q [NCH];
   logic [5:0] atten_q [NCH];
   logic [2:0] click_q [NCH];
   logic [31:0] rd_d;
   logic addr_ok;
   logic wr_en;
   logic recall;
   logic signed [18:0] wofs;

   logic [2:0] fr_m_q;
   logic [2:0] fr_s_q;
   logic [2:0] fr_p_q;
   logic fr_edge;

   atg_pkg::atg_aln_type aln_q;
   logic [4:0] us_pre_q;
   logic us_tick;
   logic [18:0] aln_cnt_q;
   logic restart_q;

   logic [24:0] acc_q;
   logic smp_tick;
   logic [9:0] wc_dly_q;
   logic wc_arm_q;
   logic [8:0] wc_hi_q;
   logic [23:0] ch_data [NCH];

   // APB slave: read data is captured in setup, answered in access
   assign addr_ok = (paddr == `ATG_ADDR_CTRL) || (paddr == `ATG_ADDR_OFFSET)
      || (paddr == `ATG_ADDR_WCOFS) || (paddr == `ATG_ADDR_STATUS)
      || (paddr == `ATG_ADDR_CHSEL) || (paddr == `ATG_ADDR_CHPARAM);
   assign pready = psel && penable;
   assign pslverr = psel && penable && !addr_ok;
   assign wr_en = psel && penable && pwrite && addr_ok && clk_en;
   assign recall = wr_en && paddr == `ATG_ADDR_CTRL
      && pwdata[`ATG_CTRL_RECALL];
   assign wofs = signed'(pwdata[18:0]);

   always_comb begin
      rd_d = 32'h00000000;
      unique case (paddr)
         `ATG_ADDR_CTRL: begin
            rd_d[`ATG_CTRL_RES24] = res24_q;
            rd_d[`ATG_CTRL_SYNC_HI:`ATG_CTRL_SYNC_LO] = sync_q;
         end
         `ATG_ADDR_OFFSET: rd_d = 32'(ofs_q);
         `ATG_ADDR_WCOFS: rd_d[4:0] = wc_ofs_q;
         `ATG_ADDR_STATUS: rd_d = {29'h0, word_clk, restart_q, aln_q};
         `ATG_ADDR_CHSEL: rd_d[2:0] = chsel_q;
         `ATG_ADDR_CHPARAM: begin
            rd_d[`ATG_CHP_FREQ_HI:`ATG_CHP_FREQ_LO] = freq_q[chsel_q];
            rd_d[`ATG_CHP_ATTEN_HI:`ATG_CHP_ATTEN_LO] = atten_q[chsel_q];
            rd_d[`ATG_CHP_CLICK_HI:`ATG_CHP_CLICK_LO] = click_q[chsel_q];
         end
         default: rd_d = 32'h00000000;
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         prdata <= 32'h00000000;
      end else if (clk_en && psel && !penable) begin
         prdata <= rd_d;
      end
   end

   // Global settings
   always_ff @(posedge clk) begin
      if (sys_rst || recall) begin
         res24_q <= `ATG_RST_RES24;
         sync_q <= atg_pkg::ATG_SYNC_FREE;
      end else if (wr_en && paddr == `ATG_ADDR_CTRL) begin
         res24_q <= pwdata[`ATG_CTRL_RES24];
         sync_q <= atg_pkg::atg_sync_type'(
            pwdata[`ATG_CTRL_SYNC_HI:`ATG_CTRL_SYNC_LO]);
      end
   end

   // Out-of-range offsets are dropped rather than clamped
   always_ff @(posedge clk) begin
      if (sys_rst || recall) begin
         ofs_q <= `ATG_RST_OFS;
      end else if (wr_en && paddr == `ATG_ADDR_CTRL
                   && pwdata[`ATG_CTRL_OFSCLR]) begin
         ofs_q <= `ATG_RST_OFS;
      end else if (wr_en && paddr == `ATG_ADDR_OFFSET
                   && sync_q != atg_pkg::ATG_SYNC_FREE
                   && int'(wofs) <= `ATG_OFS_MAX_US
                   && int'(wofs) >= -`ATG_OFS_MAX_US) begin
         ofs_q <= wofs;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wc_ofs_q <= `ATG_RST_WCOFS;
      end else if (wr_en && paddr == `ATG_ADDR_WCOFS
                   && pwdata[4:0] <= 5'(`ATG_WC_OFS_MAX_US)) begin
         wc_ofs_q <= pwdata[4:0];
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         chsel_q <= 3'h0;
      end else if (wr_en && paddr == `ATG_ADDR_CHSEL) begin
         chsel_q <= pwdata[2:0];
      end
   end

   // Per-channel parameter sets; illegal values are ignored
   always_ff @(posedge clk) begin
      if (sys_rst || recall) begin
         for (int i = 0; i < NCH; i++) begin
            freq_q[i] <= `ATG_RST_FREQ;
            atten_q[i] <= `ATG_RST_ATTEN;
            click_q[i] <= `ATG_RST_CLICK;
         end
      end else if (wr_en && paddr == `ATG_ADDR_CHPARAM) begin
         freq_q[chsel_q] <= pwdata[`ATG_CHP_FREQ_HI:`ATG_CHP_FREQ_LO];
         if (pwdata[`ATG_CHP_ATTEN_HI:`ATG_CHP_ATTEN_LO]
             <= 6'(`ATG_ATTEN_MAX)) begin
            atten_q[chsel_q] <=
               pwdata[`ATG_CHP_ATTEN_HI:`ATG_CHP_ATTEN_LO];
         end
         if (pwdata[`ATG_CHP_CLICK_HI:`ATG_CHP_CLICK_LO]
             <= 3'(`ATG_CLICK_MAX)) begin
            click_q[chsel_q] <=
               pwdata[`ATG_CHP_CLICK_HI:`ATG_CHP_CLICK_LO];
         end
      end
   end

   // Frame-reset pins cross in two flops, the third finds the edge
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         fr_m_q <= 3'h0;
         fr_s_q <= 3'h0;
         fr_p_q <= 3'h0;
      end else if (clk_en) begin
         fr_m_q <= fr_pulse;
         fr_s_q <= fr_m_q;
         fr_p_q <= fr_s_q;
      end
   end

   always_comb begin
      unique case (sync_q)
         atg_pkg::ATG_SYNC_FR1: fr_edge = fr_s_q[0] && !fr_p_q[0];
         atg_pkg::ATG_SYNC_FR2: fr_edge = fr_s_q[1] && !fr_p_q[1];
         atg_pkg::ATG_SYNC_FR3: fr_edge = fr_s_q[2] && !fr_p_q[2];
         atg_pkg::ATG_SYNC_FREE: fr_edge = 1'b0;
      endcase
   end

   // Microsecond prescaler for offset counting
   assign us_tick = (us_pre_q == 5'(`ATG_US_CYC - 1));

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         us_pre_q <= 5'h00;
      end else if (clk_en) begin
         us_pre_q <= us_tick ? 5'h00 : us_pre_q + 5'h01;
      end
   end

   // The audio origin sits 160 ms after each pulse, so negative
   // offsets can land before that origin without predicting pulses.
   // Each pulse re-arms, which covers a restarted frame reset.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         aln_q <= atg_pkg::ATG_ALN_IDLE;
         aln_cnt_q <= 19'h00000;
         restart_q <= 1'b0;
      end else if (clk_en) begin
         restart_q <= 1'b0;
         if (fr_edge) begin
            aln_q <= atg_pkg::ATG_ALN_WAIT;
            aln_cnt_q <= 19'(`ATG_OFS_MAX_US + ofs_q);
         end else begin
            unique case (aln_q)
               atg_pkg::ATG_ALN_IDLE: aln_cnt_q <= 19'h00000;
               atg_pkg::ATG_ALN_WAIT: begin
                  if (sync_q == atg_pkg::ATG_SYNC_FREE) begin
                     aln_q <= atg_pkg::ATG_ALN_IDLE;
                  end else if (us_tick) begin
                     if (aln_cnt_q == 19'h00000) begin
                        aln_q <= atg_pkg::ATG_ALN_IDLE;
                        restart_q <= 1'b1;
                     end else begin
                        aln_cnt_q <= aln_cnt_q - 19'h00001;
                     end
                  end
               end
            endcase
         end
      end
   end

   // Fractional divider: exact 48 kHz on average from 25 MHz
   always_ff @(posedge clk) begin
      if (sys_rst || (clk_en && restart_q)) begin
         acc_q <= 25'h0000000;
      end else if (clk_en) begin
         if (smp_tick) begin
            acc_q <= 25'(acc_q + `ATG_FS_HZ - `ATG_CLK_HZ);
         end else begin
            acc_q <= 25'(acc_q + `ATG_FS_HZ);
         end
      end
   end

   assign smp_tick = (26'(acc_q) + 26'(`ATG_FS_HZ) >= 26'(`ATG_CLK_HZ));

   // Word clock runs regardless of channel settings
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wc_dly_q <= 10'h000;
         wc_arm_q <= 1'b0;
         wc_hi_q <= 9'h000;
         word_clk <= 1'b0;
      end else if (clk_en) begin
         if (smp_tick) begin
            wc_arm_q <= 1'b1;
            wc_dly_q <= 10'(wc_ofs_q * `ATG_US_CYC);
         end else if (wc_arm_q) begin
            if (wc_dly_q == 10'h000) begin
               wc_arm_q <= 1'b0;
            end else begin
               wc_dly_q <= wc_dly_q - 10'h001;
            end
         end
         if (wc_arm_q && !smp_tick && wc_dly_q == 10'h000) begin
            word_clk <= 1'b1;
            wc_hi_q <= 9'(`ATG_WC_HIGH_CYC - 1);
         end else if (wc_hi_q != 9'h000) begin
            wc_hi_q <= wc_hi_q - 9'h001;
         end else begin
            word_clk <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         aud_strobe <= 1'b0;
      end else if (clk_en) begin
         aud_strobe <= smp_tick;
      end
   end

   for (genvar g = 0; g < NCH; g++) begin : g_ch
      atg_chan u_chan (
         .clk(clk),
         .sys_rst(sys_rst),
         .clk_en(clk_en),
         .restart(restart_q),
         .smp_tick(smp_tick),
         .freq_code(freq_q[g]),
         .atten(atten_q[g]),
         .click_rate(click_q[g]),
         .res24(res24_q),
         .smp_data(ch_data[g]),
         .smp_active(aud_active[g])
      );
      assign aud_data[g*24 +: 24] = ch_data[g];
   end
endmodule : atg_top
`default_nettype wire

// ---- atg_cfg.svh ----
`ifndef ATG_CFG_SVH
`define ATG_CFG_SVH

// Clock and sample timing
`define ATG_CLK_HZ 25000000
`define ATG_FS_HZ 48000
`define ATG_US_PER_S 1000000
`define ATG_US_CYC (`ATG_CLK_HZ / `ATG_US_PER_S)
`define ATG_WC_HIGH_CYC (`ATG_CLK_HZ / `ATG_FS_HZ / 2)
`define ATG_MUTE_MS 250
`define ATG_MS_PER_S 1000
`define ATG_MUTE_SMP (`ATG_FS_HZ * `ATG_MUTE_MS / `ATG_MS_PER_S)
`define ATG_CLICK_SMP (`ATG_MUTE_SMP / 2)
`define ATG_OFS_MAX_US 160000
`define ATG_WC_OFS_MAX_US 20
`define ATG_NCH 8
`define ATG_ATTEN_MAX 60
`define ATG_CLICK_MAX 4
`define ATG_DB_PER_SHIFT 6

// Register byte addresses
`define ATG_ADDR_CTRL 8'h00
`define ATG_ADDR_OFFSET 8'h04
`define ATG_ADDR_WCOFS 8'h08
`define ATG_ADDR_STATUS 8'h0C
`define ATG_ADDR_CHSEL 8'h10
`define ATG_ADDR_CHPARAM 8'h14

// Field positions
`define ATG_CTRL_RES24 0
`define ATG_CTRL_SYNC_LO 1
`define ATG_CTRL_SYNC_HI 2
`define ATG_CTRL_RECALL 8
`define ATG_CTRL_OFSCLR 9
`define ATG_CHP_FREQ_LO 0
`define ATG_CHP_FREQ_HI 4
`define ATG_CHP_ATTEN_LO 8
`define ATG_CHP_ATTEN_HI 13
`define ATG_CHP_CLICK_LO 16
`define ATG_CHP_CLICK_HI 18

// Reset and factory values
`define ATG_RST_FREQ 5'h0D
`define ATG_RST_ATTEN 6'h14
`define ATG_RST_CLICK 3'h0
`define ATG_RST_RES24 1'b0
`define ATG_RST_OFS 19'h00000
`define ATG_RST_WCOFS 5'h00
`define ATG_FREQ_INACTIVE 5'h00
`define ATG_FREQ_SILENCE 5'h01
`define ATG_FULL_SCALE 23'h7FFFFF

`endif

// ---- atg_pkg.sv ----
package atg_pkg;
   typedef enum logic [1:0] {
      ATG_SYNC_FREE = 2'b00,
      ATG_SYNC_FR1 = 2'b01,
      ATG_SYNC_FR2 = 2'b10,
      ATG_SYNC_FR3 = 2'b11
   } atg_sync_type;

   typedef enum logic {
      ATG_ALN_IDLE = 1'b0,
      ATG_ALN_WAIT = 1'b1
   } atg_aln_type;
endpackage : atg_pkg

// ---- atg_chan.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "atg_cfg.svh"

module atg_chan (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic restart,
   input wire logic smp_tick,
   input wire logic [4:0] freq_code,
   input wire logic [5:0] atten,
   input wire logic [2:0] click_rate,
   input wire logic res24,
   output logic [23:0] smp_data,
   output logic smp_active
);
   logic [23:0] phase_q;
   logic [17:0] click_cnt_q;
   logic [17:0] click_per;
   logic [22:0] x;
   logic [45:0] prod;
   logic [22:0] mag;
   logic [16:0] gain;
   logic [39:0] scaled;
   logic [23:0] lvl;
   logic [3:0] shift;
   logic [2:0] frac;
   logic [23:0] tone_d;
   logic clicks_on;

   // Phase step per sample, 24-bit accumulator at the sample rate
   function automatic logic [23:0] step_of(input logic [4:0] code);
      case (code)
         5'h02: step_of = 24'h004444;
         5'h03: step_of = 24'h008889;
         5'h04: step_of = 24'h00CCCD;
         5'h05: step_of = 24'h011111;
         5'h06: step_of = 24'h015555;
         5'h07: step_of = 24'h01999A;
         5'h08: step_of = 24'h022222;
         5'h09: step_of = 24'h02AAAB;
         5'h0A: step_of = 24'h033333;
         5'h0B: step_of = 24'h040000;
         5'h0C: step_of = 24'h044444;
         5'h0D: step_of = 24'h055555;
         5'h0E: step_of = 24'h066666;
         5'h0F: step_of = 24'h080000;
         5'h10: step_of = 24'h088889;
         5'h11: step_of = 24'h0AAAAB;
         5'h12: step_of = 24'h0CCCCD;
         5'h13: step_of = 24'h100000;
         5'h14: step_of = 24'h111111;
         5'h15: step_of = 24'h155555;
         5'h16: step_of = 24'h19999A;
         5'h17: step_of = 24'h1AAAAB;
         5'h18: step_of = 24'h200000;
         5'h19: step_of = 24'h2AAAAB;
         5'h1A: step_of = 24'h333333;
         5'h1B: step_of = 24'h355555;
         5'h1C: step_of = 24'h400000;
         5'h1D: step_of = 24'h500000;
         5'h1E: step_of = 24'h555555;
         5'h1F: step_of = 24'h6AAAAB;
         default: step_of = 24'h000000;
      endcase
   endfunction : step_of

   // Gain within one 6 dB step, Q16
   function automatic logic [16:0] gain_of(input logic [2:0] r);
      case (r)
         3'h0: gain_of = 17'h10000;
         3'h1: gain_of = 17'h0E429;
         3'h2: gain_of = 17'h0CB59;
         3'h3: gain_of = 17'h0B53C;
         3'h4: gain_of = 17'h0A186;
         default: gain_of = 17'h08FF6;
      endcase
   endfunction : gain_of

   assign clicks_on = (click_rate != 3'h0);
   assign click_per = 18'(click_rate * `ATG_FS_HZ);

   always_ff @(posedge clk) begin
      if (sys_rst || (clk_en && restart)) begin
         phase_q <= 24'h000000;
      end else if (clk_en && smp_tick) begin
         phase_q <= phase_q + step_of(freq_code);
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst || (clk_en && restart)) begin
         click_cnt_q <= 18'h00000;
      end else if (clk_en && smp_tick) begin
         if (!clicks_on || click_cnt_q + 18'h00001 >= click_per) begin
            click_cnt_q <= 18'h00000;
         end else begin
            click_cnt_q <= click_cnt_q + 18'h00001;
         end
      end
   end

   // Parabolic sine, a cheap shape traded against harmonic purity
   always_comb begin
      x = phase_q[22:0];
      prod = 46'(x) * (46'h800000 - 46'(x));
      mag = prod[44] ? `ATG_FULL_SCALE : prod[43:21];
      if (clicks_on && click_cnt_q == 18'(`ATG_CLICK_SMP)) begin
         mag = `ATG_FULL_SCALE;
      end
      shift = 4'(atten / `ATG_DB_PER_SHIFT);
      frac = 3'(atten % `ATG_DB_PER_SHIFT);
      gain = gain_of(frac);
      scaled = 40'(mag) * 40'(gain);
      lvl = 24'(scaled[39:16] >> shift);
      tone_d = phase_q[23] ? -lvl : lvl;
      if (clicks_on && click_cnt_q == 18'(`ATG_CLICK_SMP)) begin
         tone_d = lvl;
      end else if (clicks_on && click_cnt_q < 18'(`ATG_MUTE_SMP)) begin
         tone_d = 24'h000000;
      end
      if (freq_code == `ATG_FREQ_SILENCE
          || freq_code == `ATG_FREQ_INACTIVE) begin
         tone_d = 24'h000000;
      end
      if (!res24) begin
         tone_d = {tone_d[23:4], 4'h0};
      end
   end

   always_ff @(posedge clk) begin
      // Held through a restart, so data stands until the next strobe
      if (sys_rst) begin
         smp_data <= 24'h000000;
         smp_active <= 1'b0;
      end else if (clk_en && smp_tick) begin
         smp_data <= tone_d;
         smp_active <= (freq_code != `ATG_FREQ_INACTIVE);
      end
   end
endmodule : atg_chan
`default_nettype wire

// ---- atg_monitor.sv ----
`timescale 1ns/100ps
`default_nettype none
module atg_monitor (
   input wire logic clk,
   input wire logic clk_en,
   input wire logic sys_rst,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [2:0] fr_pulse,
   input wire logic [191:0] aud_data,
   input wire logic [7:0] aud_active,
   input wire logic aud_strobe,
   input wire logic word_clk
);
   logic wr;
   logic res_q;
   logic [1:0] sync_q;
   logic [4:0] wcofs_q;
   logic [9:0] gap_q;
   logic seen_q;
   logic [9:0] hi_q;
   logic low_nib;
   assign wr = psel && penable && pwrite && clk_en;
   always_comb begin
      low_nib = 1'b0;
      for (int g = 0; g < 8; g++) low_nib = low_nib | (|aud_data[g*24+:4]);
   end
   // Shadow of the settings the assertions depend on; recall wins
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         res_q <= 1'b0;
         sync_q <= 2'h0;
      end else if (wr && paddr == 8'h00) begin
         res_q <= pwdata[0] & ~pwdata[8];
         sync_q <= pwdata[8] ? 2'h0 : pwdata[2:1];
      end
   end
   always_ff @(posedge clk) begin
      if (sys_rst) wcofs_q <= 5'h00;
      else if (wr && paddr == 8'h08 && pwdata[4:0] <= 5'h14) wcofs_q <= pwdata[4:0];
   end
   // Gap is only trusted after a strobe seen in free run, restarts break it
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         gap_q <= 10'h000;
         seen_q <= 1'b0;
      end else if (clk_en) begin
         if (aud_strobe) gap_q <= 10'h000;
         else if (gap_q != 10'h3FF) gap_q <= gap_q + 10'h001;
         if (sync_q != 2'h0) seen_q <= 1'b0;
         else if (aud_strobe) seen_q <= 1'b1;
      end
   end
   always_ff @(posedge clk) begin
      if (sys_rst || !word_clk) hi_q <= 10'h000;
      else if (hi_q != 10'h3FF) hi_q <= hi_q + 10'h001;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   sequence s_acc;
      psel && penable;
   endsequence
   sequence s_tick;
      aud_strobe ##1 !aud_strobe;
   endsequence
   chk_apb_ready: assert property (s_acc |-> pready)
      else $error("pready low in access phase");
   chk_unmapped_err: assert property (s_acc and paddr > 8'h14 |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   chk_strobe_pulse: assert property (aud_strobe |-> s_tick)
      else $error("strobe longer than one cycle");
   chk_data_hold: assert property (!aud_strobe |-> $stable(aud_data))
      else $error("sample data changed between strobes");
   chk_rate_free: assert property (aud_strobe && seen_q |-> gap_q inside {10'h207, 10'h208})
      else $error("sample period wrong in free run");
   chk_wc_high: assert property ($fell(word_clk) |-> hi_q == 10'h104)
      else $error("word clock high time wrong");
   chk_wc_align: assert property (aud_strobe && wcofs_q == 5'h00 && $past(wcofs_q) == 5'h00 |=> $rose(word_clk))
      else $error("word clock not aligned to sample tick");
   chk_res_trunc: assert property (aud_strobe && !res_q && !$past(res_q, 2) |-> !low_nib)
      else $error("low bits set in 20 bit mode");
   chk_reset_quiet: assert property (disable iff (1'b0) sys_rst |=> !aud_strobe && !word_clk && aud_active == 8'h00)
      else $error("outputs not cleared by reset");
endmodule : atg_monitor

bind atg_top atg_monitor u_atg_monitor (.clk(clk), .clk_en(clk_en),
   .sys_rst(sys_rst), .paddr(paddr), .psel(psel), .penable(penable),
   .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .fr_pulse(fr_pulse), .aud_data(aud_data),
   .aud_active(aud_active), .aud_strobe(aud_strobe), .word_clk(word_clk));
`default_nettype wire

// ---- atg_sink.sv ----
`timescale 1ns/100ps
`default_nettype none
// Downstream receiver: latches each frame of eight samples on the strobe
module atg_sink (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic aud_strobe,
   input wire logic [191:0] aud_data,
   input wire logic [7:0] aud_active,
   output logic [191:0] frame_q,
   output logic [7:0] act_q,
   output logic [15:0] frame_cnt_q
);
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         frame_q <= '0;
         act_q <= 8'h00;
         frame_cnt_q <= 16'h0000;
      end else if (aud_strobe) begin
         frame_q <= aud_data;
         act_q <= aud_active;
         frame_cnt_q <= frame_cnt_q + 16'h0001;
      end
   end
endmodule : atg_sink
`default_nettype wire

// ---- aes_test_tone_generator_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module aes_test_tone_generator_tb;
   logic clk, sys_rst, clk_en, psel, penable, pwrite, pready, pslverr;
   logic aud_strobe, word_clk;
   logic [7:0] paddr, aud_active, act;
   logic [31:0] pwdata, prdata;
   logic [2:0] fr_pulse;
   logic [191:0] aud_data, frame;
   logic [15:0] fcnt;
   int error_cnt = 0;
   int compares = 0;
   int cyc = 0;
   atg_top u_atg_top (.clk(clk), .clk_en(clk_en), .sys_rst(sys_rst),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .fr_pulse(fr_pulse), .aud_data(aud_data), .aud_active(aud_active),
      .aud_strobe(aud_strobe), .word_clk(word_clk));
   atg_sink u_atg_sink (.clk(clk), .sys_rst(sys_rst), .aud_strobe(aud_strobe),
      .aud_data(aud_data), .aud_active(aud_active), .frame_q(frame),
      .act_q(act), .frame_cnt_q(fcnt));
   initial clk = 1'b0;
   always #20 clk = ~clk;
   task automatic test_done();
      if (error_cnt == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : test_done
   // Run is about 40k cycles; the ceiling leaves margin
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         error_cnt++;
         test_done();
      end
   end
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      @(posedge clk);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(a, 1'b1, d, r, e);
   endtask : wr
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string name);
      logic [31:0] r;
      logic e;
      apb(a, 1'b0, 32'h0, r, e);
      chk(name, exp, r);
   endtask : rdc
   task automatic wait_strobe(output int n);
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (aud_strobe !== 1'b1 && n < 2000);
   endtask : wait_strobe
   // Pulse 100 cycles after a strobe; normal next strobe is ~417 later
   task automatic pulse_gap(input logic [2:0] b, output int n);
      int m;
      wait_strobe(m);
      repeat (100) @(posedge clk);
      fr_pulse <= b;
      repeat (3) @(posedge clk);
      fr_pulse <= 3'h0;
      wait_strobe(n);
   endtask : pulse_gap
   function automatic logic [31:0] pval(input int g);
      logic [4:0] f;
      f = (g == 3) ? 5'h00 : (g == 5) ? 5'h01 : (g == 6) ? 5'h1F : 5'(g + 2);
      return {13'h0, 3'(g % 5), 2'h0, (g == 7) ? 6'h3C : 6'(g * 8), 3'h0, f};
   endfunction : pval
   task automatic t_defaults();
      int n;
      rdc(8'h00, 32'h0, "ctrl");
      rdc(8'h04, 32'h0, "offset");
      for (int g = 0; g < 8; g++) begin
         wr(8'h10, 32'(g));
         rdc(8'h14, 32'h0000140D, "chparam");
      end
      wait_strobe(n);
      chk("active", 32'hFF, {24'h0, aud_active});
   endtask : t_defaults
   task automatic t_unmapped();
      logic [31:0] r;
      logic e;
      apb(8'h18, 1'b0, 32'h0, r, e);
      chk("unmapped_err", 32'h1, {31'h0, e});
      chk("unmapped_data", 32'h0, r);
   endtask : t_unmapped
   task automatic t_tone();
      int n;
      logic pos, neg;
      pos = 1'b0;
      neg = 1'b0;
      repeat (48) begin
         wait_strobe(n);
         if ($signed(frame[23:0]) > 0 || $signed(aud_data[23:0]) > 0) pos = 1'b1;
         if ($signed(aud_data[23:0]) < 0) neg = 1'b1;
      end
      chk("tone_swing", 32'h3, {30'h0, pos, neg});
   endtask : t_tone
   task automatic t_channels();
      int n;
      for (int g = 0; g < 8; g++) begin
         wr(8'h10, 32'(g));
         wr(8'h14, pval(g));
      end
      for (int g = 0; g < 8; g++) begin
         wr(8'h10, 32'(g));
         rdc(8'h14, pval(g), "chparam");
      end
      wait_strobe(n);
      wait_strobe(n);
      chk("active", 32'hF7, {24'h0, act});
      chk("silence", 32'h0, {8'h0, frame[5*24+:24]});
      chk("mute", 32'h0, {8'h0, frame[1*24+:24]});
      wr(8'h10, 32'h0);
      wr(8'h14, 32'h00053D09);
      rdc(8'h14, 32'h00000009, "chparam_range");
   endtask : t_channels
   task automatic t_wclk();
      int n;
      wr(8'h08, 32'h15);
      rdc(8'h08, 32'h0, "wcofs");
      wr(8'h08, 32'h2);
      rdc(8'h08, 32'h2, "wcofs");
      wait_strobe(n);
      wait_strobe(n);
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (word_clk !== 1'b1 && n < 600);
      chk("wc_delay", 32'h33, 32'(n));
      wr(8'h08, 32'h0);
   endtask : t_wclk
   task automatic t_frame();
      int n;
      for (int s = 1; s < 4; s++) begin
         wr(8'h00, 32'(s << 1));
         wr(8'h04, 32'hFFFD8F00);
         wr(8'h04, 32'h00027101);
         rdc(8'h04, 32'hFFFD8F00, "offset");
         pulse_gap(3'(1 << (s % 3)), n);
         chk("gap_other", 32'h1, 32'(n <= 420));
         pulse_gap(3'(1 << (s - 1)), n);
         chk("gap_sel", 32'h1, 32'(n >= 500));
      end
      wr(8'h04, 32'hFFFD8F0A);
      pulse_gap(3'h4, n);
      chk("gap_delay", 32'h1, 32'(n >= 750));
      wr(8'h04, 32'hFFFD8F00);
      wr(8'h00, 32'h0);
      wr(8'h04, 32'h5);
      rdc(8'h04, 32'hFFFD8F00, "offset_free");
      pulse_gap(3'h7, n);
      chk("gap_free", 32'h1, 32'(n <= 420));
      wr(8'h00, 32'h200);
      rdc(8'h04, 32'h0, "offset_clear");
   endtask : t_frame
   task automatic t_recall();
      wr(8'h00, 32'h1);
      rdc(8'h00, 32'h1, "ctrl_res");
      wr(8'h00, 32'h103);
      t_defaults();
   endtask : t_recall
   initial begin
      sys_rst = 1'b1;
      clk_en = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      fr_pulse = 3'h0;
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      t_defaults();
      t_unmapped();
      t_tone();
      t_channels();
      t_wclk();
      t_frame();
      t_recall();
      test_done();
   end
endmodule : aes_test_tone_generator_tb
`default_nettype wire
